// [oht_pkg.sv]
/*
 * oht_pkg: register offsets, field positions, reset values and timing constants
 * for the overheat pin timer block.
 * Assumes a 200 MHz core clock and 8-bit registers at their printed offsets.
 */
package oht_pkg;

    // register offsets
    localparam logic [7:0] OHT_REMOTE1_LIMIT_OFS = 8'h6a;
    localparam logic [7:0] OHT_LOCAL_LIMIT_OFS   = 8'h6b;
    localparam logic [7:0] OHT_REMOTE2_LIMIT_OFS = 8'h6c;
    localparam logic [7:0] OHT_ALERT_MASK_TWO_OFS = 8'h75;
    localparam logic [7:0] OHT_CONFIG_THREE_OFS  = 8'h78;
    localparam logic [7:0] OHT_ASSERT_TIMER_OFS  = 8'h79;
    localparam logic [7:0] OHT_TIMER_LIMIT_OFS   = 8'h7a;
    localparam logic [7:0] OHT_CONFIG_FIVE_OFS   = 8'h7c;
    localparam logic [7:0] OHT_CONFIG_FOUR_OFS   = 8'h7d;
    localparam logic [7:0] OHT_STATUS_TWO_OFS    = 8'h42;

    // field positions
    localparam int OHT_C3_ALERT_PIN5_BIT   = 0;
    localparam int OHT_C3_MONITOR_EN_BIT   = 1;
    localparam int OHT_C3_FULL_SPEED_BIT   = 2;
    localparam int OHT_C4_LATCH_FULL_SPEED_OVERRIDE_DIS  = 2;
    localparam int OHT_C4_LATCH_SEL_BIT    = 3;
    localparam int OHT_C5_DRIVE_R1_BIT     = 5;
    localparam int OHT_ST_LATCH_BIT        = 0;
    localparam int OHT_ST_OVERTEMP_BIT     = 1;
    localparam int OHT_ST_FAN4_TIMER_BIT   = 5;
    localparam int OHT_MASK_OVERTEMP_BIT   = 1;
    localparam int OHT_MASK_FAN4_TIMER_BIT = 5;

    // pin 9 function codes
    typedef enum logic [1:0] {
        OHT_PIN9_OVERHEAT = 2'b00,
        OHT_PIN9_FAN4     = 2'b01,
        OHT_PIN9_GPIO     = 2'b10,
        OHT_PIN9_ALERT    = 2'b11
    } oht_pin9_fn_t;

    // reset values
    localparam logic [7:0] OHT_LIMIT_RST         = 8'hff;
    localparam logic [7:0] OHT_LATCH_R1_LIMIT_RST = 8'ha4;  // 100 C, offset-64 code
    localparam logic [7:0] OHT_LATCH_R2_LIMIT_RST = 8'hc8;  // 136 C, offset-64 code
    localparam logic [7:0] OHT_REG_RST           = 8'h00;

    // disable codes for the limit
    localparam logic [7:0] OHT_OFS64_FLOOR = 8'h00;
    localparam logic [7:0] OHT_TWOS_FLOOR  = 8'h80;

    // timing
    localparam int OHT_CLK_PERIOD_PS = 5000;
    localparam longint OHT_TICK_PS   = 64'd22760000000;  // 22.76 ms timer resolution
    localparam int OHT_TICK_CYCLES   = int'(OHT_TICK_PS / OHT_CLK_PERIOD_PS);

    localparam logic [7:0] OHT_TIMER_MAX = 8'hff;

endpackage : oht_pkg

// [oht_sync2.sv]
/*
 * oht_sync2: two-flop synchroniser for one level.
 * Assumes the input is asynchronous to clk; reset value is a parameter.
 */
`timescale 1ns/100ps
module oht_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic meta_q;

    // first flop feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : oht_sync2

// [oht_chan_cmp.sv]
/*
 * oht_chan_cmp: one temperature channel against its overheat limit.
 * Assumes temp carries two fraction bits and meas_valid pulses once per conversion.
 */
`timescale 1ns/100ps
module oht_chan_cmp
    import oht_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic       twos_mode,
    input  wire logic [9:0] temp,
    input  wire logic       meas_valid,
    input  wire logic [7:0] limit,
    output logic            over_q,
    output logic            below
);
    logic [9:0] temp_u;
    logic [9:0] lim_u;
    logic       lim_off;
    logic       over_hold_q;

    // flipping the sign bit turns twos complement into an ordered unsigned code
    assign temp_u  = twos_mode ? {~temp[9], temp[8:0]} : temp;
    assign lim_u   = twos_mode ? {~limit[7], limit[6:0], 2'b00} : {limit, 2'b00};
    assign lim_off = twos_mode ? (limit == OHT_TWOS_FLOOR) : (limit == OHT_OFS64_FLOOR);
    assign below   = temp_u < lim_u;
    // a limit moved to the floor code releases at once, not one edge after the write
    assign over_q  = over_hold_q && !lim_off;

    // besides a disable or the floor limit, only a fresh measurement may release, so low lasts at least one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            over_hold_q <= 1'b0;
        end else if (!enable || lim_off) begin
            over_hold_q <= 1'b0;
        end else if (meas_valid) begin
            over_hold_q <= temp_u > lim_u;
        end
    end
endmodule : oht_chan_cmp

// [oht_overheat_ctrl.sv]
/*
 * oht_overheat_ctrl: overheat pin, assertion timer, timer limit flag, alert
 * routing, full speed override and the latch variant.
 * Assumes the serial interface turns transactions into one-cycle reg_wr/reg_rd
 * strobes on core_clk, and the converter supplies readings with a valid pulse.
 */
`timescale 1ns/100ps
module oht_overheat_ctrl
    import oht_pkg::*;
#(
    parameter bit LATCH_VARIANT = 1'b0,
    parameter int TICK_CYCLES   = OHT_TICK_CYCLES,
    parameter int NUM_FANS      = 4
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // register access strobes from the serial interface
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [7:0]               reg_rdata,
    // temperature readings, two fraction bits
    input  wire logic [9:0]          remote1_temp,
    input  wire logic [9:0]          local_temp,
    input  wire logic [9:0]          remote2_temp,
    input  wire logic [2:0]          meas_valid,
    input  wire logic                temp_twos_mode,
    // fan side
    input  wire logic [NUM_FANS-1:0] fan_running,
    input  wire logic                fan4_speed_low,
    output logic [NUM_FANS-1:0]      fan_full_speed,
    // pin 9, open drain
    input  wire logic                pin9_in,
    output logic                     pin9_out,
    output logic                     pin9_oe,
    // pin 5, open drain
    output logic                     pin5_out,
    output logic                     pin5_oe,
    output logic [1:0]               pin9_function_select
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] remote1_overheat_limit_q;
    logic [7:0] local_overheat_limit_q;
    logic [7:0] remote2_overheat_limit_q;
    logic [7:0] alert_mask_two_q;
    logic [7:0] config_three_q;
    logic [7:0] assertion_timer_limit_q;
    logic [7:0] config_five_q;
    logic [7:0] config_four_q;
    logic [7:0] reg_rdata_q;

    logic       wr_r1;
    logic       wr_loc;
    logic       wr_r2;
    logic       rd_timer;
    logic       rd_status;

    assign wr_r1     = reg_wr && (reg_addr == OHT_REMOTE1_LIMIT_OFS);
    assign wr_loc    = reg_wr && (reg_addr == OHT_LOCAL_LIMIT_OFS);
    assign wr_r2     = reg_wr && (reg_addr == OHT_REMOTE2_LIMIT_OFS);
    assign rd_timer  = reg_rd && (reg_addr == OHT_ASSERT_TIMER_OFS);
    assign rd_status = reg_rd && (reg_addr == OHT_STATUS_TWO_OFS);

    // limits: separate remote 1 and remote 2 reset values on the latch variant
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            remote1_overheat_limit_q <= LATCH_VARIANT ? OHT_LATCH_R1_LIMIT_RST : OHT_LIMIT_RST;
            local_overheat_limit_q   <= OHT_LIMIT_RST;
            remote2_overheat_limit_q <= LATCH_VARIANT ? OHT_LATCH_R2_LIMIT_RST : OHT_LIMIT_RST;
        end else begin
            if (wr_r1) begin
                remote1_overheat_limit_q <= reg_wdata;
            end
            if (wr_loc) begin
                local_overheat_limit_q <= reg_wdata;
            end
            if (wr_r2) begin
                remote2_overheat_limit_q <= reg_wdata;
            end
        end
    end

    // configuration: everything off after reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alert_mask_two_q        <= OHT_REG_RST;
            config_three_q          <= OHT_REG_RST;
            assertion_timer_limit_q <= OHT_REG_RST;
            config_five_q           <= OHT_REG_RST;
            config_four_q           <= OHT_REG_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                OHT_ALERT_MASK_TWO_OFS: begin
                    alert_mask_two_q <= reg_wdata;
                end
                OHT_CONFIG_THREE_OFS: begin
                    config_three_q <= reg_wdata;
                end
                OHT_TIMER_LIMIT_OFS: begin
                    assertion_timer_limit_q <= reg_wdata;
                end
                OHT_CONFIG_FIVE_OFS: begin
                    config_five_q <= reg_wdata;
                end
                OHT_CONFIG_FOUR_OFS: begin
                    config_four_q <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin 9 function and enable

    oht_pin9_fn_t pin9_fn;
    logic         monitor_en;
    logic         pin_sync;
    logic         pin_asserted;

    assign pin9_fn              = oht_pin9_fn_t'(config_four_q[1:0]);
    assign pin9_function_select = config_four_q[1:0];
    assign monitor_en           = (pin9_fn == OHT_PIN9_OVERHEAT)
                                  && config_three_q[OHT_C3_MONITOR_EN_BIT];

    oht_sync2 #(
        .RST_VAL (1'b1)
    ) u_pin_sync (
        .clk   (core_clk),
        .rst_n (rst_n),
        .d     (pin9_in),
        .q     (pin_sync)
    );

    // the wire level covers both our own drive and an external pull low
    assign pin_asserted = monitor_en && !pin_sync;

    ////////////////////////////////////////////////////////////////////////////
    // channel comparison

    logic [2:0] over;
    logic [2:0] below;
    logic [2:0] drive_en;
    logic       drive_low;

    assign drive_en = config_five_q[OHT_C5_DRIVE_R1_BIT +: 3];

    oht_chan_cmp u_cmp_r1 (
        .clk        (core_clk),
        .rst_n      (rst_n),
        .enable     (config_three_q[OHT_C3_MONITOR_EN_BIT]),
        .twos_mode  (temp_twos_mode),
        .temp       (remote1_temp),
        .meas_valid (meas_valid[0]),
        .limit      (remote1_overheat_limit_q),
        .over_q     (over[0]),
        .below      (below[0])
    );

    oht_chan_cmp u_cmp_loc (
        .clk        (core_clk),
        .rst_n      (rst_n),
        .enable     (config_three_q[OHT_C3_MONITOR_EN_BIT]),
        .twos_mode  (temp_twos_mode),
        .temp       (local_temp),
        .meas_valid (meas_valid[1]),
        .limit      (local_overheat_limit_q),
        .over_q     (over[1]),
        .below      (below[1])
    );

    oht_chan_cmp u_cmp_r2 (
        .clk        (core_clk),
        .rst_n      (rst_n),
        .enable     (config_three_q[OHT_C3_MONITOR_EN_BIT]),
        .twos_mode  (temp_twos_mode),
        .temp       (remote2_temp),
        .meas_valid (meas_valid[2]),
        .limit      (remote2_overheat_limit_q),
        .over_q     (over[2]),
        .below      (below[2])
    );

    // with no drive bit set the pin is only an input in the overheat function
    assign drive_low = monitor_en && |(over & drive_en);

    ////////////////////////////////////////////////////////////////////////////
    // assertion timer

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    logic [TICK_W-1:0] tick_cnt_q;
    logic              tick;
    logic [7:0]        ticks_q;
    logic              seen_q;
    logic [7:0]        timer_value;

    assign tick = pin_asserted && (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

    // sub-count pauses while deasserted so partial periods accumulate
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
        end else if (rd_timer) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else if (pin_asserted) begin
            tick_cnt_q <= tick_cnt_q + TICK_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ticks_q <= 8'h00;
            seen_q  <= 1'b0;
        end else if (rd_timer) begin
            ticks_q <= 8'h00;
            seen_q  <= pin_asserted;
        end else begin
            if (pin_asserted) begin
                seen_q <= 1'b1;
            end
            if (tick && ticks_q != OHT_TIMER_MAX) begin
                ticks_q <= ticks_q + 8'h01;
            end
        end
    end

    // below two ticks the register only shows that an assertion happened
    assign timer_value = (ticks_q >= 8'h02) ? ticks_q : {7'h00, seen_q};

    ////////////////////////////////////////////////////////////////////////////
    // status two and latch

    logic timer_over;
    logic fan4_event;
    logic flag5_q;
    logic latch_q;
    logic latch_stat_q;
    logic latch_over;
    logic latch_below;
    logic overtemp;

    assign timer_over  = monitor_en && (timer_value > assertion_timer_limit_q);
    assign fan4_event  = timer_over || ((pin9_fn == OHT_PIN9_FAN4) && fan4_speed_low);
    assign latch_over  = config_four_q[OHT_C4_LATCH_SEL_BIT] ? over[0] : over[2];
    assign latch_below = config_four_q[OHT_C4_LATCH_SEL_BIT] ? below[0] : below[2];
    assign overtemp    = drive_low;

    // sticky; a set in the read cycle wins over the clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flag5_q <= 1'b0;
        end else if (fan4_event) begin
            flag5_q <= 1'b1;
        end else if (rd_status) begin
            flag5_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            latch_q      <= 1'b0;
            latch_stat_q <= 1'b0;
        end else if (LATCH_VARIANT) begin
            if (latch_over) begin
                latch_q      <= 1'b1;
                latch_stat_q <= 1'b1;
            end else begin
                if (rd_status && latch_below) begin
                    latch_stat_q <= 1'b0;
                end
                if (!latch_stat_q && latch_below) begin
                    latch_q <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alert and pins

    logic alert;
    logic alert_pin5;

    assign alert      = (flag5_q && !alert_mask_two_q[OHT_MASK_FAN4_TIMER_BIT])
                        || (overtemp && !alert_mask_two_q[OHT_MASK_OVERTEMP_BIT]);
    assign alert_pin5 = !LATCH_VARIANT && config_three_q[OHT_C3_ALERT_PIN5_BIT];

    // both pins are open drain: the output level is always low
    assign pin9_out = 1'b0;
    assign pin5_out = 1'b0;
    assign pin9_oe  = ((pin9_fn == OHT_PIN9_ALERT) && alert)
                      || drive_low;
    assign pin5_oe  = LATCH_VARIANT ? latch_q : (alert_pin5 && alert);

    ////////////////////////////////////////////////////////////////////////////
    // fan override

    logic full_speed_override_req;
    logic latch_req;

    assign full_speed_override_req = config_three_q[OHT_C3_FULL_SPEED_BIT] && pin_asserted;
    assign latch_req = latch_q && !config_four_q[OHT_C4_LATCH_FULL_SPEED_OVERRIDE_DIS];

    // stopped fans stay stopped; the fan logic reports which ones are running
    assign fan_full_speed = (full_speed_override_req || latch_req) ? fan_running : '0;

    ////////////////////////////////////////////////////////////////////////////
    // read data

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                OHT_REMOTE1_LIMIT_OFS:  reg_rdata_q <= remote1_overheat_limit_q;
                OHT_LOCAL_LIMIT_OFS:    reg_rdata_q <= local_overheat_limit_q;
                OHT_REMOTE2_LIMIT_OFS:  reg_rdata_q <= remote2_overheat_limit_q;
                OHT_ALERT_MASK_TWO_OFS: reg_rdata_q <= alert_mask_two_q;
                OHT_CONFIG_THREE_OFS:   reg_rdata_q <= config_three_q;
                OHT_ASSERT_TIMER_OFS:   reg_rdata_q <= timer_value;
                OHT_TIMER_LIMIT_OFS:    reg_rdata_q <= assertion_timer_limit_q;
                OHT_CONFIG_FIVE_OFS:    reg_rdata_q <= config_five_q;
                OHT_CONFIG_FOUR_OFS:    reg_rdata_q <= config_four_q;
                OHT_STATUS_TWO_OFS: begin
                    reg_rdata_q <= {2'b00, flag5_q, 3'b000, overtemp, latch_stat_q};
                end
                default:                reg_rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_q;

endmodule : oht_overheat_ctrl

// [oht_ctrl_chk.sv]
/* oht_ctrl_chk: port-level assertions for the overheat controller.
   Assumes it is bound into every oht_overheat_ctrl and sees only its ports. */
`timescale 1ns/100ps
module oht_ctrl_chk #(
    parameter int NUM_FANS = 4
) (
    input wire logic                core_clk,
    input wire logic                rst_n,
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    input wire logic [2:0]          meas_valid,
    input wire logic [NUM_FANS-1:0] fan_running,
    input wire logic [NUM_FANS-1:0] fan_full_speed,
    input wire logic                pin9_in,
    input wire logic                pin9_out,
    input wire logic                pin9_oe,
    input wire logic                pin5_oe,
    input wire logic [1:0]          pin9_function_select
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    chk_reset_quiet: assert property (
        $rose(rst_n) |-> !pin5_oe && !pin9_oe && fan_full_speed == '0) else $error("pins active after reset");
    chk_fn_select: assert property (
        reg_wr && reg_addr == 8'h7d |=> {6'h00, pin9_function_select} == ($past(reg_wdata) & 8'h03))
        else $error("pin 9 function not taken from write");
    chk_fan_running: assert property (
        (fan_full_speed & ~fan_running) == '0) else $error("stopped fan forced to full speed");
    chk_pin_open: assert property (
        pin9_oe |-> !pin9_out && (pin9_function_select == 2'b00 || pin9_function_select == 2'b11))
        else $error("pin 9 driven high or driven in an input function");
    // oe follows registers and readings only, so no other cause may move it
    chk_drive_cause: assert property (
        $changed(pin9_oe) && pin9_function_select == 2'b00 |-> $past(meas_valid) != 3'h0 || $past(reg_wr))
        else $error("pin 9 drive moved without a reading");
    chk_limit_store: assert property (
        (reg_wr && reg_addr == 8'h6a) ##2 (reg_rd && reg_addr == 8'h6a) |=> reg_rdata == $past(reg_wdata, 3))
        else $error("limit readback differs");
    chk_clear_read: assert property (
        (pin9_in [*4] ##0 (reg_rd && reg_addr == 8'h79)) ##1 pin9_in ##1 (pin9_in && reg_rd && reg_addr == 8'h79)
        |=> reg_rdata == 8'h00) else $error("timer not cleared by read");
    chk_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata)) else $error("read data moved without a read");
endmodule : oht_ctrl_chk
bind oht_overheat_ctrl oht_ctrl_chk #(.NUM_FANS(NUM_FANS)) i_oht_ctrl_chk (.core_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .meas_valid, .fan_running, .fan_full_speed, .pin9_in, .pin9_out, .pin9_oe,
    .pin5_oe, .pin9_function_select);

// [oht_cpu_hot_model.sv]
/* oht_cpu_hot_model: far-side hot signal sharing the open-drain overheat pin.
   Assumes a pull-up on the wire and hot_req driven by the bench. */
`timescale 1ns/100ps
module oht_cpu_hot_model (
    input  wire logic hot_req,
    input  wire logic pin9_oe,
    output logic      pin9_wire
);
    // either party pulls low; a released wire rises through the pull-up
    assign pin9_wire = !(hot_req || pin9_oe);
endmodule : oht_cpu_hot_model

// [oht_overheat_ctrl_tb_top.sv]
/* oht_overheat_ctrl_tb_top: register-level tests of the overheat controller.
   Assumes a tick of 8 cycles and the hot-signal model on pin 9. */
`timescale 1ns/100ps
module oht_overheat_ctrl_tb_top;
    logic       core_clk, rst_n, reg_wr, reg_rd, hot, pin9_w, pin9_oe, pin5_oe;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
    logic [9:0] r1_temp;
    logic [2:0] meas_valid;
    logic [3:0] fan_run, fan_full;
    logic [1:0] pin9_fn;
    int         n_mismatch = 0, compares = 0, cyc = 0;
    oht_overheat_ctrl #(.TICK_CYCLES(8)) i_oht_overheat_ctrl (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .remote1_temp(r1_temp), .local_temp(10'h000), .remote2_temp(10'h000), .meas_valid,
        .temp_twos_mode(1'b0), .fan_running(fan_run), .fan4_speed_low(1'b0), .fan_full_speed(fan_full),
        .pin9_in(pin9_w), .pin9_out(), .pin9_oe, .pin5_out(), .pin5_oe, .pin9_function_select(pin9_fn));
    oht_cpu_hot_model i_oht_cpu_hot_model (.hot_req(hot), .pin9_oe, .pin9_wire(pin9_w));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // the saturation run dominates; the ceiling leaves ample slack over it
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
        cmp(got, e);
    endtask : chk_rd
    task automatic hold_hot(input int n);
        @(posedge core_clk) hot <= 1'b1;
        repeat (n) @(posedge core_clk);
        hot <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : hold_hot
    task automatic meas(input logic [9:0] t);
        @(posedge core_clk);
        r1_temp    <= t;
        meas_valid <= 3'h1;
        @(posedge core_clk);
        meas_valid <= 3'h0;
        #1;
    endtask : meas
    task automatic tally_and_finish;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, reg_wr, reg_rd, hot, meas_valid, reg_addr, reg_wdata, r1_temp} = '0;
        fan_run = 4'h5;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        chk_rd(8'h6a, 8'hff);
        chk_rd(8'h78, 8'h00);
        chk_rd(8'h10, 8'h00);
        for (int c = 3; c >= 0; c--) begin
            wr(8'h7d, 8'(c));
            cmp({6'h00, pin9_fn}, 8'(c));
        end
        wr(8'h78, 8'h02);
        wr(8'h7a, 8'h00);
        @(posedge core_clk) hot <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk_rd(8'h79, 8'h01);
        @(posedge core_clk) hot <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk_rd(8'h79, 8'h01);
        chk_rd(8'h79, 8'h00);
        hold_hot(20);
        hold_hot(24);
        chk_rd(8'h79, 8'h05);
        chk_rd(8'h42, 8'h20);
        chk_rd(8'h42, 8'h00);
        hold_hot(2100);
        chk_rd(8'h79, 8'hff);
        wr(8'h7d, 8'h03);
        cmp({7'h00, pin9_oe}, 8'h01);
        wr(8'h78, 8'h03);
        cmp({7'h00, pin5_oe}, 8'h01);
        wr(8'h75, 8'h20);
        cmp({7'h00, pin9_oe}, 8'h00);
        cmp({7'h00, pin5_oe}, 8'h00);
        chk_rd(8'h42, 8'h20);
        wr(8'h7d, 8'h00);
        wr(8'h6a, 8'h50);
        wr(8'h7c, 8'h20);
        meas(10'h140);
        cmp({7'h00, pin9_oe}, 8'h00);
        meas(10'h141);
        cmp({7'h00, pin9_oe}, 8'h01);
        meas(10'h140);
        cmp({7'h00, pin9_oe}, 8'h00);
        wr(8'h6a, 8'h00);
        chk_rd(8'h6a, 8'h00);
        meas(10'h3ff);
        cmp({7'h00, pin9_oe}, 8'h00);
        wr(8'h78, 8'h06);
        @(posedge core_clk) hot <= 1'b1;
        repeat (4) @(posedge core_clk);
        cmp({4'h0, fan_full}, 8'h05);
        @(posedge core_clk) hot <= 1'b0;
        repeat (4) @(posedge core_clk);
        cmp({4'h0, fan_full}, 8'h00);
        tally_and_finish();
    end
endmodule : oht_overheat_ctrl_tb_top
